// ===== core/ocp_pkg.sv
// Constants for the overcurrent protection block: register map, fields and timing
package ocp_pkg;
	// Time bases
	localparam int CLK_MHZ          = 125;
	localparam int FAST_TICK_US     = 3300;
	localparam int FAST_TICK_CYCLES = FAST_TICK_US * CLK_MHZ;
	localparam int SLOW_TICK_MS     = 1000;
	localparam int SLOW_TICK_CYCLES = SLOW_TICK_MS * 1000 * CLK_MHZ;
	localparam logic [8:0] DLY_BASE = 9'h002;
	localparam logic [16:0] THR_BASE_MV = 17'h0_0004;

	// Register byte addresses
	localparam logic [7:0] ADDR_ENABLE   = 8'h00;
	localparam logic [7:0] ADDR_FET_CTRL = 8'h04;
	localparam logic [7:0] ADDR_CHG_CFG  = 8'h08;
	localparam logic [7:0] ADDR_L12_CFG  = 8'h0C;
	localparam logic [7:0] ADDR_L3_CFG   = 8'h10;
	localparam logic [7:0] ADDR_REC_CFG  = 8'h14;
	localparam logic [7:0] ADDR_REC_THR  = 8'h18;
	localparam logic [7:0] ADDR_LATCH_THR = 8'h1C;
	localparam logic [7:0] ADDR_STATUS   = 8'h20;
	localparam logic [7:0] ADDR_COMMAND  = 8'h24;
	localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
	localparam int NUM_CFG = 8;

	// Per-protection bit positions (enable, FET control, alert, fault)
	localparam int P_CHG   = 0;
	localparam int P_L1    = 1;
	localparam int P_L2    = 2;
	localparam int P_L3    = 3;
	localparam int P_LATCH = 4;
	localparam int EN_CUR_REC  = 5;
	localparam int EN_TIME_REC = 6;
	localparam int CMD_LATCH_RECOVER = 0;

	// Field LSBs
	localparam int CHG_THR_LSB = 0;
	localparam int CHG_DLY_LSB = 8;
	localparam int L1_THR_LSB  = 0;
	localparam int L1_DLY_LSB  = 8;
	localparam int L2_THR_LSB  = 16;
	localparam int L2_DLY_LSB  = 24;
	localparam int L3_THR_LSB  = 0;
	localparam int L3_DLY_LSB  = 16;
	localparam int REC_TIME_LSB  = 0;
	localparam int LATCH_LIM_LSB = 8;
	localparam int DEC_DLY_LSB   = 16;
	localparam int LREC_TIME_LSB = 24;
	localparam int CHG_REC_LSB   = 0;
	localparam int DSG_REC_LSB   = 16;
	localparam int LATCH_REC_LSB = 0;
	localparam int DELTA_LSB     = 16;
	localparam int ST_ALERT_LSB  = 0;
	localparam int ST_FAULT_LSB  = 8;
	localparam int ST_COUNT_LSB  = 16;
	localparam int ST_CHG_FET    = 24;
	localparam int ST_DSG_FET    = 25;

	// Persistence timer slots
	localparam int NUM_TMR   = 9;
	localparam int T_CHG     = 0;
	localparam int T_L1      = 1;
	localparam int T_L2      = 2;
	localparam int T_L3      = 3;
	localparam int T_CHG_REC = 4;
	localparam int T_DSG_REC = 5;
	localparam int T_DEC     = 6;
	localparam int T_LCUR    = 7;
	localparam int T_LTIME   = 8;
	localparam logic [8:0] TMR_FAST_MASK = 9'h007;
endpackage

// ===== core/persist_timer.sv
// Persistence timer: raises done once a condition has held for limit ticks
`timescale 1ns/100ps
module persist_timer (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       tick_in,
	input  wire logic       cond_in,
	input  wire logic [8:0] limit_in,
	output logic            done_out
);
	logic [8:0] count_reg;

	// Any gap in the condition restarts the count, so only continuous persistence expires
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_reg <= 9'h000;
			done_out  <= 1'b0;
		end else if (!cond_in) begin
			count_reg <= 9'h000;
			done_out  <= 1'b0;
		end else if (count_reg >= limit_in) begin
			done_out <= 1'b1;
		end else if (tick_in) begin
			count_reg <= count_reg + 9'h001;
		end
	end
endmodule

// ===== core/overcurrent_protection_fsm.sv
// Charge and discharge overcurrent protection with latch counter and APB registers
// What this block does
// (RULE1) Charge threshold 4-124 mV, gated by enable; the 6-bit field here reaches 130 mV
// (RULE2) Charge alert above threshold; fault after delay
// (RULE3) Charge delay setting zero disables charge protection
// (RULE4) Charge trip: alert clears, fault, charge FET off
// (RULE5) Charge recovery by terminal_voltage_a drop or low current
// (RULE6) Levels 1,2 thresholds 4-200 mV, own enables; the 7-bit fields here reach 258 mV
// (RULE7) Levels 1,2 alert, then fault after own delay
// (RULE8) Level 3 alerts when current below signed threshold
// (RULE9) Level 3 delay 0-255 s, own enable
// (RULE10) Discharge faults raise discharge FET off if autonomous
// (RULE11) Charging current persisting recovers all discharge faults
// (RULE12) Each discharge trip increments latch counter
// (RULE13) Counter decrements each interval after recovery
// (RULE14) Latched fault when counter exceeds limit, enabled
// (RULE15) Latch alert whenever counter is nonzero
// (RULE16) Latch clears: load removed, current, time, command
// (RULE17) Current latch recovery needs config, series, charge FET
// (RULE18) Host may emulate time recovery via current threshold
// (RULE19) Delay timers restart when condition drops early
// (RULE20) Latch drives discharge FET off; reset clears counter
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
module overcurrent_protection_fsm
	import ocp_pkg::*;
#(
	parameter int FAST_TICK = FAST_TICK_CYCLES,
	parameter int SLOW_TICK = SLOW_TICK_CYCLES
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic [15:0] sense_positive_input_in,
	input  wire logic [15:0] sense_negative_input_in,
	input  wire logic [15:0] coulomb_counter_current_in,
	input  wire logic [15:0] terminal_voltage_a_in,
	input  wire logic [15:0] stack_voltage_in,
	input  wire logic        load_removed_in,
	input  wire logic        series_fet_config_in,
	input  wire logic        charge_fet_enabled_in,
	output logic             charge_fet_off_request_out,
	output logic             discharge_fet_off_request_out
);
	logic [31:0] cfg_reg [0:NUM_CFG-1];
	logic [31:0] fast_cnt_reg;
	logic [31:0] slow_cnt_reg;
	logic [4:0]  alert_reg;
	logic [4:0]  fault_reg;
	logic [7:0]  latch_cnt_reg;
	logic [4:0]  alert_next;
	logic [4:0]  fault_next;
	logic [7:0]  latch_cnt_next;
	logic [8:0]  tmr_cond;
	logic [8:0]  tmr_done;
	logic [8:0]  tmr_limit [0:NUM_TMR-1];

	// APB decode: zero-wait answer one cycle after setup, error on unmapped words
	wire        apb_setup  = psel_in & ~penable_in;
	wire        apb_done   = psel_in & penable_in & pready_out;
	wire        addr_ok    = (paddr_in[1:0] == 2'b00) && (paddr_in <= ADDR_COMMAND);
	wire        cfg_hit    = addr_ok && (paddr_in < ADDR_STATUS);
	wire        cfg_wr     = apb_done & pwrite_in & cfg_hit;
	wire [2:0]  cfg_idx    = paddr_in[4:2];
	wire        cmd_wr     = apb_done & pwrite_in & addr_ok & (paddr_in == ADDR_COMMAND);
	wire        recover_cmd = cmd_wr & pwdata_in[CMD_LATCH_RECOVER];

	// Configuration fields
	wire [31:0] en_r      = cfg_reg[ADDR_ENABLE[4:2]];
	wire [31:0] fet_r     = cfg_reg[ADDR_FET_CTRL[4:2]];
	wire [31:0] chg_r     = cfg_reg[ADDR_CHG_CFG[4:2]];
	wire [31:0] l12_r     = cfg_reg[ADDR_L12_CFG[4:2]];
	wire [31:0] l3_r      = cfg_reg[ADDR_L3_CFG[4:2]];
	wire [31:0] rec_r     = cfg_reg[ADDR_REC_CFG[4:2]];
	wire [31:0] rthr_r    = cfg_reg[ADDR_REC_THR[4:2]];
	wire [31:0] lthr_r    = cfg_reg[ADDR_LATCH_THR[4:2]];
	wire [5:0]  chg_thr   = chg_r[CHG_THR_LSB +: 6];
	wire [6:0]  chg_dly   = chg_r[CHG_DLY_LSB +: 7];
	wire [6:0]  l1_thr    = l12_r[L1_THR_LSB +: 7];
	wire [6:0]  l1_dly    = l12_r[L1_DLY_LSB +: 7];
	wire [6:0]  l2_thr    = l12_r[L2_THR_LSB +: 7];
	wire [6:0]  l2_dly    = l12_r[L2_DLY_LSB +: 7];
	wire signed [15:0] l3_thr  = l3_r[L3_THR_LSB +: 16];
	wire [7:0]  l3_dly    = l3_r[L3_DLY_LSB +: 8];
	wire [7:0]  rec_time  = rec_r[REC_TIME_LSB +: 8];
	wire [7:0]  latch_lim = rec_r[LATCH_LIM_LSB +: 8];
	wire [7:0]  dec_dly   = rec_r[DEC_DLY_LSB +: 8];
	wire [7:0]  lrec_time = rec_r[LREC_TIME_LSB +: 8];
	wire signed [15:0] chg_rec_thr = rthr_r[CHG_REC_LSB +: 16];
	wire signed [15:0] dsg_rec_thr = rthr_r[DSG_REC_LSB +: 16];
	wire signed [15:0] latch_thr   = lthr_r[LATCH_REC_LSB +: 16];
	wire [15:0] terminal_voltage_a_delta = lthr_r[DELTA_LSB +: 16];

	// Register writes, one word per slot
	genvar gi;
	for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
		always_ff @(posedge core_clk_in or posedge rst_in) begin
			if (rst_in) begin
				cfg_reg[gi] <= CFG_RESET;
			end else if (cfg_wr && cfg_idx == 3'(gi)) begin
				cfg_reg[gi] <= pwdata_in;
			end
		end
	end

	// Tick dividers: 3.3 ms base for sense delays, 1 s base for current timers
	wire fast_tick = (fast_cnt_reg == 32'(FAST_TICK - 1));
	wire slow_tick = (slow_cnt_reg == 32'(SLOW_TICK - 1));
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			fast_cnt_reg <= 32'h0000_0000;
			slow_cnt_reg <= 32'h0000_0000;
		end else begin
			fast_cnt_reg <= fast_tick ? 32'h0000_0000 : fast_cnt_reg + 32'h0000_0001;
			slow_cnt_reg <= slow_tick ? 32'h0000_0000 : slow_cnt_reg + 32'h0000_0001;
		end
	end

	// Sense voltages in mV; threshold is base plus two per code step
	wire signed [16:0] chg_diff = $signed({1'b0, sense_positive_input_in}) - $signed({1'b0, sense_negative_input_in});
	wire signed [16:0] dsg_diff = $signed({1'b0, sense_negative_input_in}) - $signed({1'b0, sense_positive_input_in});
	wire signed [16:0] chg_thr_mv = $signed(THR_BASE_MV + {10'h000, chg_thr, 1'b0}); // RULE1
	wire signed [16:0] l1_thr_mv  = $signed(THR_BASE_MV + {9'h000, l1_thr, 1'b0}); // RULE6
	wire signed [16:0] l2_thr_mv  = $signed(THR_BASE_MV + {9'h000, l2_thr, 1'b0}); // RULE6
	wire signed [15:0] cur = coulomb_counter_current_in;

	// Detection conditions; delay setting zero kills the charge check outright
	wire chg_det = en_r[P_CHG] && (chg_dly != 7'h00) && (chg_diff > chg_thr_mv); // RULE1 RULE3
	wire l1_det  = en_r[P_L1] && (dsg_diff > l1_thr_mv); // RULE6
	wire l2_det  = en_r[P_L2] && (dsg_diff > l2_thr_mv); // RULE6
	wire l3_det  = en_r[P_L3] && (cur < l3_thr); // RULE8 RULE9
	wire [3:0] det = {l3_det, l2_det, l1_det, chg_det};

	// Recovery conditions
	wire terminal_voltage_a_low = $signed({1'b0, terminal_voltage_a_in}) <=
		($signed({1'b0, stack_voltage_in}) - $signed({1'b0, terminal_voltage_a_delta})); // RULE5
	wire chg_rec_cond = fault_reg[P_CHG] && (terminal_voltage_a_low || cur <= chg_rec_thr); // RULE5
	wire dsg_rec_cond = (|fault_reg[P_L3:P_L1]) && (cur >= dsg_rec_thr); // RULE11
	wire lcur_cond = fault_reg[P_LATCH] && en_r[EN_CUR_REC] && series_fet_config_in
		&& charge_fet_enabled_in && (cur >= latch_thr); // RULE17
	wire ltime_cond = fault_reg[P_LATCH] && en_r[EN_TIME_REC];

	// Trip pulses are the first cycle a timer expires with no fault yet
	wire [3:0] trip = tmr_done[3:0] & ~fault_reg[3:0];
	wire any_dsg_trip = |trip[P_L3:P_L1];
	wire chg_rec = tmr_done[T_CHG_REC];
	wire dsg_rec = tmr_done[T_DSG_REC];
	wire dec_pulse = tmr_done[T_DEC];
	wire latch_reset = fault_reg[P_LATCH] && (load_removed_in || tmr_done[T_LCUR]
		|| tmr_done[T_LTIME] || recover_cmd); // RULE16

	// Decrement interval only runs with the counter up and every discharge fault gone
	wire dec_cond = (latch_cnt_reg != 8'h00) && !(|fault_reg[P_L3:P_L1])
		&& !any_dsg_trip && !dec_pulse; // RULE13

	// Timer wiring: conditions and limits per slot
	assign tmr_cond = {ltime_cond, lcur_cond, dec_cond, dsg_rec_cond, chg_rec_cond, det};
	assign tmr_limit[T_CHG]     = DLY_BASE + {2'b00, chg_dly}; // RULE2
	assign tmr_limit[T_L1]      = DLY_BASE + {2'b00, l1_dly}; // RULE7
	assign tmr_limit[T_L2]      = DLY_BASE + {2'b00, l2_dly}; // RULE7
	assign tmr_limit[T_L3]      = {1'b0, l3_dly}; // RULE9
	assign tmr_limit[T_CHG_REC] = {1'b0, rec_time};
	assign tmr_limit[T_DSG_REC] = {1'b0, rec_time};
	assign tmr_limit[T_DEC]     = {1'b0, dec_dly};
	assign tmr_limit[T_LCUR]    = {1'b0, lrec_time};
	assign tmr_limit[T_LTIME]   = {1'b0, lrec_time};

	// One persistence timer per slot; sense slots count 3.3 ms, the rest seconds
	for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
		persist_timer u_timer (
			.clk_in   (core_clk_in),
			.rst_in   (rst_in),
			.tick_in  (TMR_FAST_MASK[gi] ? fast_tick : slow_tick),
			.cond_in  (tmr_cond[gi]), // RULE19
			.limit_in (tmr_limit[gi]),
			.done_out (tmr_done[gi])
		);
	end

	// Fault flags: a trip in the same cycle as recovery keeps the fault
	assign fault_next[P_CHG] = trip[P_CHG] | (fault_reg[P_CHG] & ~chg_rec); // RULE4 RULE5
	assign fault_next[P_L3:P_L1] = trip[P_L3:P_L1] | (fault_reg[P_L3:P_L1] & {3{~dsg_rec}}); // RULE7 RULE11
	assign fault_next[P_LATCH] = (en_r[P_LATCH] && latch_cnt_next > latch_lim)
		|| (fault_reg[P_LATCH] && !latch_reset); // RULE14 RULE20

	// Latch counter: reset first, then a trip counts up, then the interval counts down
	wire [7:0] cnt_base = latch_reset ? 8'h00 : latch_cnt_reg; // RULE20
	assign latch_cnt_next = any_dsg_trip ? ((cnt_base == 8'hFF) ? cnt_base : cnt_base + 8'h01) // RULE12
		: (dec_pulse && cnt_base != 8'h00) ? cnt_base - 8'h01 : cnt_base; // RULE13

	// Charge and level alerts follow detection but drop once the matching fault is set; the latch alert follows the counter
	assign alert_next[3:0] = det & ~fault_next[3:0]; // RULE2 RULE4 RULE7 RULE8
	assign alert_next[P_LATCH] = (latch_cnt_next != 8'h00); // RULE15

	wire chg_fet_next = fault_next[P_CHG] & fet_r[P_CHG]; // RULE4
	wire dsg_fet_next = |(fault_next[P_LATCH:P_L1] & fet_r[P_LATCH:P_L1]); // RULE10 RULE20

	// Protection state registers
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			alert_reg <= 5'h00;
			fault_reg <= 5'h00;
			latch_cnt_reg <= 8'h00;
			charge_fet_off_request_out <= 1'b0;
			discharge_fet_off_request_out <= 1'b0;
		end else begin
			alert_reg <= alert_next;
			fault_reg <= fault_next;
			latch_cnt_reg <= latch_cnt_next;
			charge_fet_off_request_out <= chg_fet_next;
			discharge_fet_off_request_out <= dsg_fet_next;
		end
	end

	// Read mux; status is sampled at setup so it lags live state by a cycle
	wire [31:0] status_word = {6'h00, discharge_fet_off_request_out, charge_fet_off_request_out,
		latch_cnt_reg, 3'h0, fault_reg, 3'h0, alert_reg};
	wire [31:0] rd_data = cfg_hit ? cfg_reg[cfg_idx]
		: (addr_ok && paddr_in == ADDR_STATUS) ? status_word : 32'h0000_0000;

	// APB answer registers
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else begin
			pready_out  <= apb_setup;
			pslverr_out <= apb_setup & ~addr_ok;
			prdata_out  <= apb_setup ? rd_data : prdata_out;
		end
	end

	// Checks
	chk_charge_disabled: // RULE3
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		(chg_dly == 7'h00) |=> !alert_reg[P_CHG] && !tmr_done[T_CHG])
		else $error("charge protection active with zero delay");
	chk_charge_alert: // RULE2
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		alert_reg[P_CHG] |-> $past(chg_det) && !fault_reg[P_CHG])
		else $error("charge alert without detection");
	chk_charge_fet: // RULE4
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		$past(trip[P_CHG] && fet_r[P_CHG]) |-> charge_fet_off_request_out && fault_reg[P_CHG])
		else $error("charge trip did not request charge FET off");
	chk_dsg_fet_l3: // RULE10
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		$past(fault_next[P_L3] && fet_r[P_L3]) |-> discharge_fet_off_request_out)
		else $error("level 3 fault without discharge FET off");
	chk_dsg_recover: // RULE11
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		dsg_rec && !any_dsg_trip |=> fault_reg[P_L3:P_L1] == 3'b000)
		else $error("discharge faults not cleared on recovery");
	chk_latch_count_up: // RULE12
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		any_dsg_trip && !latch_reset && latch_cnt_reg != 8'hFF |=> latch_cnt_reg == $past(latch_cnt_reg) + 8'h01)
		else $error("latch counter missed a discharge trip");
	chk_latch_set: // RULE14
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		en_r[P_LATCH] && latch_cnt_reg > latch_lim && !latch_reset |=> fault_reg[P_LATCH])
		else $error("latched fault not raised above limit");
	chk_latch_alert: // RULE15
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		alert_reg[P_LATCH] == (latch_cnt_reg != 8'h00))
		else $error("latch alert disagrees with counter");
	chk_latch_reset: // RULE20
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		latch_reset && !any_dsg_trip |=> latch_cnt_reg == 8'h00 && !fault_reg[P_LATCH])
		else $error("latch reset left counter or fault");
	chk_timer_restart: // RULE19
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		!tmr_cond[T_L1] |=> !tmr_done[T_L1])
		else $error("level 1 timer survived a dropped condition");

	// Alerts only follow a live, enabled detection
	chk_l1_alert: // RULE7
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		alert_reg[P_L1] |-> $past(l1_det) && !fault_reg[P_L1])
		else $error("level 1 alert without detection");
	chk_l2_alert: // RULE7
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		alert_reg[P_L2] |-> $past(l2_det) && !fault_reg[P_L2])
		else $error("level 2 alert without detection");
	chk_l3_alert: // RULE8
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		alert_reg[P_L3] |-> $past(l3_det))
		else $error("level 3 alert without detection");
	chk_l2_trip_alert: // RULE7
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		fault_reg[P_L2] |-> !alert_reg[P_L2])
		else $error("level 2 alert kept after trip");

	// A cleared enable bit silences the matching check on the next edge
	chk_chg_enable: // RULE1
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		!en_r[P_CHG] |=> !alert_reg[P_CHG])
		else $error("charge alert while disabled");
	chk_l2_enable: // RULE6
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		!en_r[P_L2] |=> !alert_reg[P_L2])
		else $error("level 2 alert while disabled");
	chk_l3_enable: // RULE9
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		!en_r[P_L3] |=> !alert_reg[P_L3])
		else $error("level 3 alert while disabled");
	chk_latch_disabled: // RULE14
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		!en_r[P_LATCH] && !fault_reg[P_LATCH] |=> !fault_reg[P_LATCH])
		else $error("latched fault raised while disabled");

	// FET requests follow the faults and the autonomous control bits
	chk_chg_recover: // RULE5
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		chg_rec && !trip[P_CHG] |=> !fault_reg[P_CHG] && !charge_fet_off_request_out)
		else $error("charge fault not cleared on recovery");
	chk_chg_fet_only: // RULE4
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		$past(fault_next[P_CHG] && !(|fault_next[P_LATCH:P_L1])) |-> !discharge_fet_off_request_out)
		else $error("charge fault touched the discharge FET");
	chk_dsg_fet_l1: // RULE10
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		$past(fault_next[P_L1] && fet_r[P_L1]) |-> discharge_fet_off_request_out)
		else $error("level 1 fault without discharge FET off");
	chk_dsg_fet_l2: // RULE10
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		$past(fault_next[P_L2] && fet_r[P_L2]) |-> discharge_fet_off_request_out)
		else $error("level 2 fault without discharge FET off");
	chk_latch_fet: // RULE20
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		$past(fault_next[P_LATCH] && fet_r[P_LATCH]) |-> discharge_fet_off_request_out)
		else $error("latched fault without discharge FET off");

	// Latch counter walks down and clears as the recovery paths demand
	chk_latch_count_down: // RULE13
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		dec_pulse && !any_dsg_trip && !latch_reset && latch_cnt_reg != 8'h00
		|=> latch_cnt_reg == $past(latch_cnt_reg) - 8'h01)
		else $error("latch counter missed a decrement");
	chk_latch_cur_rec: // RULE17
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		tmr_done[T_LCUR] && fault_reg[P_LATCH] && !any_dsg_trip
		|=> latch_cnt_reg == 8'h00 && !fault_reg[P_LATCH])
		else $error("current latch recovery did not clear");

	// An error answer always rides on a ready cycle
	chk_pslverr_ready:
	assert property (@(posedge core_clk_in) disable iff (rst_in)
		pslverr_out |-> pready_out)
		else $error("bus error without ready");
endmodule

// ===== testbench/apb_host_model.sv
// Host model: issues APB register transfers toward the protection block
`timescale 1ns/100ps
module apb_host_model
	import ocp_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic [31:0] prdata_in,
	input  wire logic        pready_in,
	input  wire logic        pslverr_in,
	output logic             psel_out,
	output logic             penable_out,
	output logic             pwrite_out,
	output logic [7:0]       paddr_out,
	output logic [31:0]      pwdata_out
);
	// Idle bus at time zero so the block never sees a stray request
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0000_0000;
	end

	// One transfer; held until pready is seen at a rising edge, with no bound on the wait
	task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= wr;
		paddr_out <= addr;
		pwdata_out <= wdata;
		@(posedge clk_in);
		penable_out <= 1'b1;
		// Only the bench timeout ends a wait that never sees pready
		do begin
			@(posedge clk_in);
		end while (pready_in !== 1'b1);
		rdata = prdata_in;
		err = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// Released data lines do not keep the old value
		pwdata_out <= ~wdata;
		paddr_out <= ~addr;
	endtask

	task automatic apb_write(input logic [7:0] addr, input logic [31:0] wdata);
		logic [31:0] d;
		logic        e;
		apb_xfer(1'b1, addr, wdata, d, e);
	endtask

	task automatic apb_read(input logic [7:0] addr, output logic [31:0] rdata, output logic err);
		apb_xfer(1'b0, addr, 32'h0000_0000, rdata, err);
	endtask

	// Host subcommand that releases a latched discharge fault
	task automatic send_latch_recover;
		apb_write(ADDR_COMMAND, 32'h0000_0001);
	endtask
endmodule

// ===== testbench/test_overcurrent_protection_fsm.sv
// Self-checking bench for the overcurrent protection block
`timescale 1ns/100ps
module test_overcurrent_protection_fsm;
	import ocp_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, chg_off, dsg_off, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] sp = 16'h0000;
	logic [15:0] sn = 16'h0000;
	logic [15:0] cc = 16'h0000;
	logic        load_rm = 1'b0;
	logic        ser = 1'b1;
	int          errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	// Short tick bases keep every delay but the stretched decrement within a few hundred cycles
	overcurrent_protection_fsm #(.FAST_TICK(10), .SLOW_TICK(40)) uut (
		.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .sense_positive_input_in(sp), .sense_negative_input_in(sn),
		.coulomb_counter_current_in(cc), .terminal_voltage_a_in(16'h9C40), .stack_voltage_in(16'h9C40),
		.load_removed_in(load_rm), .series_fet_config_in(ser), .charge_fet_enabled_in(1'b1),
		.charge_fet_off_request_out(chg_off), .discharge_fet_off_request_out(dsg_off));

	apb_host_model u_host (
		.clk_in(clk), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr), .psel_out(psel),
		.penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));

	always #4 clk = ~clk;

	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, well above the roughly 1300 cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			$display("mismatch timeout expected finish seen hang");
			test_done();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic st_chk(input string name, input logic [31:0] mask, input logic [31:0] exp);
		u_host.apb_read(ADDR_STATUS, rd, err);
		check(name, rd & mask, exp);
	endtask

	task automatic drive(input logic [15:0] p, input logic [15:0] n, input logic [15:0] c);
		@(posedge clk);
		sp <= p;
		sn <= n;
		cc <= c;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wait_cyc(2);
		// Reset values, refused address, read-only status
		u_host.apb_read(ADDR_ENABLE, rd, err);
		check("enable reset", rd, CFG_RESET);
		u_host.apb_read(8'h28, rd, err);
		check("unmapped error", {31'h0, err}, 32'h0000_0001);
		check("unmapped data", rd, 32'h0000_0000);
		u_host.apb_write(ADDR_STATUS, 32'hFFFF_FFFF);
		st_chk("status reset", 32'hFFFF_FFFF, 32'h0000_0000);
		// Common configuration: 1 s recovery, limit 1, 3 s decrement, level 3 at -100 mA
		u_host.apb_write(ADDR_REC_CFG, 32'h0003_0101);
		u_host.apb_write(ADDR_REC_THR, 32'h0001_0000);
		u_host.apb_write(ADDR_LATCH_THR, 32'h0064_0000);
		u_host.apb_write(ADDR_L3_CFG, 32'h0001_FF9C);
		u_host.apb_write(ADDR_L12_CFG, 32'h0060_0000);
		u_host.apb_write(ADDR_FET_CTRL, 32'h0000_001F);
		u_host.apb_write(ADDR_ENABLE, 32'h0000_000F);
		u_host.apb_read(ADDR_L3_CFG, rd, err);
		check("config readback", rd, 32'h0001_FF9C);
		// Charge: 10 mV threshold, delay setting 1
		u_host.apb_write(ADDR_CHG_CFG, 32'h0000_0103);
		drive(16'd10, 16'd0, 16'd0);
		wait_cyc(5);
		st_chk("chg alert at threshold", 32'h0000_0001, 32'h0000_0000);
		drive(16'd11, 16'd0, 16'd0);
		wait_cyc(3);
		st_chk("chg alert", 32'h0000_0101, 32'h0000_0001);
		wait_cyc(40);
		st_chk("chg trip", 32'h0300_0101, 32'h0100_0100);
		check("chg fet ports", {30'h0, dsg_off, chg_off}, 32'h0000_0001);
		drive(16'd0, 16'd0, 16'hFFFB);
		wait_cyc(100);
		st_chk("chg recovered", 32'h0100_0100, 32'h0000_0000);
		u_host.apb_write(ADDR_CHG_CFG, 32'h0000_0003);
		drive(16'd50, 16'd0, 16'd0);
		wait_cyc(40);
		st_chk("chg delay zero", 32'h0100_0101, 32'h0000_0000);
		// Level 1: short bursts never fault, a steady one does
		repeat (8) begin
			drive(16'd0, 16'd5, 16'd0);
			wait_cyc(6);
			drive(16'd0, 16'd0, 16'd0);
			wait_cyc(2);
		end
		st_chk("l1 bursts", 32'h0000_0200, 32'h0000_0000);
		drive(16'd0, 16'd5, 16'd0);
		wait_cyc(3);
		st_chk("l1 alert", 32'h0000_0202, 32'h0000_0002);
		wait_cyc(30);
		st_chk("l1 trip", 32'h02FF_0212, 32'h0201_0210);
		check("dsg fet port", {31'h0, dsg_off}, 32'h0000_0001);
		drive(16'd0, 16'd0, 16'd1);
		wait_cyc(90);
		st_chk("dsg recovered", 32'h02FF_0E12, 32'h0001_0010);
		wait_cyc(150);
		st_chk("counter decrement", 32'h00FF_0010, 32'h0000_0000);
		// Level 3 with the decrement stretched out for the latch tests
		u_host.apb_write(ADDR_REC_CFG, 32'h00FF_0101);
		drive(16'd0, 16'd0, 16'hFF9C);
		wait_cyc(5);
		st_chk("l3 at threshold", 32'h0000_0008, 32'h0000_0000);
		drive(16'd0, 16'd0, 16'hFF9B);
		wait_cyc(3);
		st_chk("l3 alert", 32'h0000_0008, 32'h0000_0008);
		wait_cyc(90);
		st_chk("l3 trip", 32'h0200_0808, 32'h0200_0800);
		drive(16'd0, 16'd0, 16'd1);
		wait_cyc(90);
		// Second trip by level 2 pushes the counter past the limit
		u_host.apb_write(ADDR_ENABLE, 32'h0000_001F);
		u_host.apb_write(ADDR_L12_CFG, 32'h0000_0060);
		drive(16'd0, 16'd5, 16'd0);
		wait_cyc(40);
		st_chk("latch trip", 32'h02FF_1410, 32'h0202_1410);
		drive(16'd0, 16'd0, 16'd1);
		wait_cyc(90);
		st_chk("latch holds fet", 32'h0200_1400, 32'h0200_1000);
		u_host.send_latch_recover();
		wait_cyc(2);
		st_chk("latch command", 32'h02FF_1010, 32'h0000_0000);
		check("dsg fet released", {31'h0, dsg_off}, 32'h0000_0000);
		// Limit zero: one trip latches, load removal clears it
		u_host.apb_write(ADDR_REC_CFG, 32'h00FF_0001);
		drive(16'd0, 16'd5, 16'd0);
		wait_cyc(40);
		st_chk("latch limit zero", 32'h0000_1000, 32'h0000_1000);
		@(posedge clk);
		load_rm <= 1'b1;
		wait_cyc(3);
		st_chk("latch load removed", 32'h00FF_1000, 32'h0000_0000);
		@(posedge clk);
		load_rm <= 1'b0;
		ser <= 1'b0;
		// Current recovery with a small discharge threshold acts as a timed release
		drive(16'd0, 16'd0, 16'd1);
		wait_cyc(90);
		u_host.apb_write(ADDR_LATCH_THR, 32'h0064_FFFF);
		u_host.apb_write(ADDR_REC_CFG, 32'h01FF_0001);
		u_host.apb_write(ADDR_ENABLE, 32'h0000_003F);
		drive(16'd0, 16'd5, 16'd0);
		wait_cyc(40);
		st_chk("latch without series fet", 32'h0000_1000, 32'h0000_1000);
		@(posedge clk);
		ser <= 1'b1;
		wait_cyc(90);
		st_chk("latch current recovery", 32'h00FF_1000, 32'h0000_0000);
		drive(16'd0, 16'd0, 16'd0);
		test_done();
	end
endmodule
